/* File: verilog/tsc_defines.vh */
`ifndef TSC_DEFINES_VH
`define TSC_DEFINES_VH

// ==========================================================
// register offsets
`define TSC_ADDR_W 12
`define TSC_OFS_TEST_CTRL 12'h032C
`define TSC_OFS_REF_LOW 12'h032D
`define TSC_OFS_REF_HIGH 12'h032E
`define TSC_OFS_RESULT 12'h032F
`define TSC_OFS_LANE_INV 12'h0334
`define TSC_OFS_DEV_IDENT 12'h0400
`define TSC_OFS_BANK_IDENT 12'h0401

// ==========================================================
// field positions in test control and result
`define TSC_SAMPLE_SEL_HI 7
`define TSC_SAMPLE_SEL_LO 4
`define TSC_CONV_SEL_HI 3
`define TSC_CONV_SEL_LO 2
`define TSC_CLEAR_BIT 1
`define TSC_ENABLE_BIT 0
`define TSC_FAIL_BIT 0

// ==========================================================
// reset values and widths
`define TSC_REG_W 8
`define TSC_RST_BYTE 8'h00
`define TSC_SAMPLE_W 16
`define TSC_SAMPLES_PER_CONV 16
`define TSC_NUM_CONV 4
`define TSC_NUM_LANES 8
`define TSC_LANE_W 32

`endif

/* File: verilog/tsc_lane_flip.v */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// one lane's polarity flip, registered output
module tsc_lane_flip #(
  parameter WIDTH = 32
) (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire flip_i,
  input wire [WIDTH-1:0] data_i,
  output wire [WIDTH-1:0] data_o
);
  reg [WIDTH-1:0] data_q;

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_q <= {WIDTH{1'b0}};
    end else begin
      data_q <= data_i ^ {WIDTH{flip_i}};
    end
  end

  assign data_o = data_q;
endmodule // tsc_lane_flip

`default_nettype wire

/* File: verilog/tsc_transport_sample_checker.v */
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defines.vh"

module tsc_transport_sample_checker #(
  parameter NUM_LANES = `TSC_NUM_LANES,
  parameter LANE_W = `TSC_LANE_W,
  parameter NUM_CONV = `TSC_NUM_CONV,
  parameter SAMPLES = `TSC_SAMPLES_PER_CONV,
  parameter SAMPLE_W = `TSC_SAMPLE_W
) (
  input wire clk_sys_i,
  input wire resetn_i,
  // configuration port
  input wire [`TSC_ADDR_W-1:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [`TSC_REG_W-1:0] reg_wdata_i,
  output wire [`TSC_REG_W-1:0] reg_rdata_o,
  output wire reg_rvalid_o,
  // deserialized lane data
  input wire [NUM_LANES*LANE_W-1:0] lane_data_i,
  output wire [NUM_LANES*LANE_W-1:0] lane_data_o,
  // receiver output samples, converter-major
  input wire [NUM_CONV*SAMPLES*SAMPLE_W-1:0] samples_i,
  input wire samples_valid_i,
  // lane 0 alignment configuration
  input wire ilas_cfg_valid_i,
  input wire [`TSC_REG_W-1:0] ilas_device_ident_i,
  input wire [`TSC_REG_W-1:0] ilas_bank_ident_i,
  // status
  output wire check_mismatch_flag_o
);

  // ==========================================================
  // registers
  reg [`TSC_REG_W-1:0] test_control_q;
  reg [`TSC_REG_W-1:0] expected_sample_low_q;
  reg [`TSC_REG_W-1:0] expected_sample_high_q;
  reg [`TSC_REG_W-1:0] lane_polarity_flip_q;
  reg [`TSC_REG_W-1:0] received_device_ident_q;
  reg [`TSC_REG_W-1:0] received_bank_ident_q;
  reg check_mismatch_flag_q;
  reg check_mismatch_flag_d;
  reg [`TSC_REG_W-1:0] rdata_q;
  reg [`TSC_REG_W-1:0] rdata_d;
  reg rvalid_q;

  wire wr_ctrl;
  wire check_result_clear;
  wire check_enable;
  wire [3:0] check_sample_select;
  wire [1:0] check_converter_select;
  wire [5:0] sample_index;
  wire [SAMPLE_W-1:0] selected_sample;
  wire [SAMPLE_W-1:0] expected_sample;
  wire mismatch;

  // ==========================================================
  // register writes
  assign wr_ctrl = reg_wr_i && (reg_addr_i == `TSC_OFS_TEST_CTRL);

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      test_control_q <= `TSC_RST_BYTE;
      expected_sample_low_q <= `TSC_RST_BYTE;
      expected_sample_high_q <= `TSC_RST_BYTE;
      lane_polarity_flip_q <= `TSC_RST_BYTE;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `TSC_OFS_TEST_CTRL: begin
          test_control_q <= reg_wdata_i;
        end
        `TSC_OFS_REF_LOW: begin
          expected_sample_low_q <= reg_wdata_i;
        end
        `TSC_OFS_REF_HIGH: begin
          expected_sample_high_q <= reg_wdata_i;
        end
        `TSC_OFS_LANE_INV: begin
          lane_polarity_flip_q <= reg_wdata_i;
        end
        default: begin
          test_control_q <= test_control_q;
        end
      endcase
    end
  end

  // ==========================================================
  // transport sample check
  assign check_enable = test_control_q[`TSC_ENABLE_BIT];
  assign check_sample_select = test_control_q[`TSC_SAMPLE_SEL_HI:`TSC_SAMPLE_SEL_LO];
  assign check_converter_select = test_control_q[`TSC_CONV_SEL_HI:`TSC_CONV_SEL_LO];
  // clear acts on the write itself, so a stored 1 cannot mask later failures
  assign check_result_clear = wr_ctrl && reg_wdata_i[`TSC_CLEAR_BIT];

  assign sample_index = {check_converter_select, check_sample_select};
  assign selected_sample = samples_i[sample_index*SAMPLE_W +: SAMPLE_W];
  // bytes are not paired on write: load both while the check is off
  assign expected_sample = {expected_sample_high_q, expected_sample_low_q};
  assign mismatch = check_enable && samples_valid_i
    && (selected_sample != expected_sample);

  always @* begin
    check_mismatch_flag_d = check_mismatch_flag_q;
    if (check_result_clear) begin
      check_mismatch_flag_d = 1'b0;
    end
    // a mismatch in the clearing cycle is kept: set wins
    if (mismatch) begin
      check_mismatch_flag_d = 1'b1;
    end
  end

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      check_mismatch_flag_q <= 1'b0;
    end else begin
      check_mismatch_flag_q <= check_mismatch_flag_d;
    end
  end

  assign check_mismatch_flag_o = check_mismatch_flag_q;

  // ==========================================================
  // lane 0 alignment identifiers
  // relies on the transmitter sending both fields on lane 0
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      received_device_ident_q <= `TSC_RST_BYTE;
      received_bank_ident_q <= `TSC_RST_BYTE;
    end else if (ilas_cfg_valid_i) begin
      received_device_ident_q <= ilas_device_ident_i;
      received_bank_ident_q <= ilas_bank_ident_i;
    end
  end

  // ==========================================================
  // register reads, one cycle latency, unmapped reads zero
  always @* begin
    rdata_d = `TSC_RST_BYTE;
    case (reg_addr_i)
      `TSC_OFS_TEST_CTRL: begin
        rdata_d = test_control_q;
      end
      `TSC_OFS_REF_LOW: begin
        rdata_d = expected_sample_low_q;
      end
      `TSC_OFS_REF_HIGH: begin
        rdata_d = expected_sample_high_q;
      end
      `TSC_OFS_RESULT: begin
        rdata_d[`TSC_FAIL_BIT] = check_mismatch_flag_q;
      end
      `TSC_OFS_LANE_INV: begin
        rdata_d = lane_polarity_flip_q;
      end
      `TSC_OFS_DEV_IDENT: begin
        rdata_d = received_device_ident_q;
      end
      `TSC_OFS_BANK_IDENT: begin
        rdata_d = received_bank_ident_q;
      end
      default: begin
        rdata_d = `TSC_RST_BYTE;
      end
    endcase
  end

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= `TSC_RST_BYTE;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // data holds until the next read, so a slow master still sees it
  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;

  // ==========================================================
  // per-lane polarity flip
  genvar g;
  generate
    for (g = 0; g < NUM_LANES; g = g + 1) begin : g_lane
      tsc_lane_flip #(
        .WIDTH(LANE_W)
      ) u_flip (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .flip_i(lane_polarity_flip_q[g]),
        .data_i(lane_data_i[g*LANE_W +: LANE_W]),
        .data_o(lane_data_o[g*LANE_W +: LANE_W])
      );
    end
  endgenerate

endmodule // tsc_transport_sample_checker

`default_nettype wire

/* File: sim/tsc_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ======
// checker on top ports
module tsc_props (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic samples_valid_i,
  input wire logic check_mismatch_flag_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  logic en_q;
  logic ctl_wr;
  assign ctl_wr = reg_wr_i && reg_addr_i == 12'h032C;
  // only the enable bit is shadowed, to keep this light
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) en_q <= 1'b0;
    else if (ctl_wr) en_q <= reg_wdata_i[0];
  end
  // clear with no compare running, since a set would win
  sequence s_clear;
    ctl_wr && reg_wdata_i[1] && !(en_q && samples_valid_i);
  endsequence
  chk_rd_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("no answer");
  chk_no_stray: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("stray");
  chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("moved");
  chk_result_byte: assert property (reg_rd_i && reg_addr_i == 12'h032F
    |=> reg_rdata_o == {7'h00, $past(check_mismatch_flag_o)}) else $error("result byte");
  chk_clear_works: assert property (s_clear |=> !check_mismatch_flag_o)
    else $error("clear");
  chk_flag_sticky: assert property (check_mismatch_flag_o
    && !(ctl_wr && reg_wdata_i[1]) |=> check_mismatch_flag_o) else $error("flag dropped");
  chk_set_cause: assert property ($rose(check_mismatch_flag_o)
    |-> $past(en_q) && $past(samples_valid_i)) else $error("set without compare");
  chk_idle_quiet: assert property (!en_q && !check_mismatch_flag_o
    |=> !check_mismatch_flag_o) else $error("set while disabled");
endmodule // tsc_props
bind tsc_transport_sample_checker tsc_props props_u (.clk_sys_i(clk_sys_i),
  .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .samples_valid_i(samples_valid_i), .check_mismatch_flag_o(check_mismatch_flag_o));
`default_nettype wire

/* File: sim/tsc_tx_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ======
// transmitter: sample ramp, lane words, lane 0 idents
module tsc_tx_model (
  input wire logic run_i,
  input wire logic send_i,
  output logic [1023:0] samples_o,
  output logic [255:0] lane_o,
  output logic [7:0] did_o,
  output logic [7:0] bid_o
);
  // idents inverted outside alignment data so stale values show
  assign did_o = send_i ? 8'h5A : 8'hA5;
  assign bid_o = send_i ? 8'hC3 : 8'h3C;
  for (genvar i = 0; i < 64; i++) begin : g_smp
    assign samples_o[i*16 +: 16] = run_i ? 16'hB000 + 16'(i) : ~(16'hB000 + 16'(i));
  end
  for (genvar n = 0; n < 8; n++) begin : g_lane
    assign lane_o[n*32 +: 32] = 32'hC3A5_0F00 + 32'(n);
  end
endmodule // tsc_tx_model
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ======
// register-level bench
module tb;
  logic clk_sys_i = 1'b0;
  logic rst_n = 1'b0;
  logic w = 1'b0, r = 1'b0, run = 1'b0, send = 1'b0;
  logic [11:0] a = 12'h000;
  logic [7:0] d = 8'h00;
  logic [3:0] s;
  logic [15:0] v;
  wire logic [7:0] rdt, dido, bido;
  wire logic rv, flag;
  wire logic [1023:0] smp;
  wire logic [255:0] lin, lout;
  int error_cnt = 0, check_count = 0;
  logic [11:0] tab [8] = '{12'h032C, 12'h032D, 12'h032E, 12'h032F, 12'h0334, 12'h0400,
    12'h0401, 12'h0000};
  initial forever #50 clk_sys_i = ~clk_sys_i;
  tsc_tx_model tx_u (.run_i(run), .send_i(send), .samples_o(smp), .lane_o(lin),
    .did_o(dido), .bid_o(bido));
  tsc_transport_sample_checker dut_u (.clk_sys_i(clk_sys_i), .resetn_i(rst_n),
    .reg_addr_i(a), .reg_wr_i(w), .reg_rd_i(r), .reg_wdata_i(d), .reg_rdata_o(rdt),
    .reg_rvalid_o(rv), .lane_data_i(lin), .lane_data_o(lout), .samples_i(smp),
    .samples_valid_i(run), .ilas_cfg_valid_i(send), .ilas_device_ident_i(dido),
    .ilas_bank_ident_i(bido), .check_mismatch_flag_o(flag));
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [11:0] ad, input logic [7:0] dt);
    @(negedge clk_sys_i);
    a = ad;
    d = dt;
    w = 1'b1;
    @(negedge clk_sys_i);
    w = 1'b0;
  endtask
  // extra idle edges let a pending flag update land before the read
  task automatic rdc(input logic [11:0] ad, input logic [7:0] ex, input string nm);
    repeat (2) @(negedge clk_sys_i);
    a = ad;
    r = 1'b1;
    @(negedge clk_sys_i);
    r = 1'b0;
    cmp("read valid", 32'h0000_0001, 32'(rv));
    cmp(nm, 32'(ex), 32'(rdt));
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (3) @(negedge clk_sys_i);
    rst_n = 1'b1;
    foreach (tab[i]) rdc(tab[i], 8'h00, "reset value");
    $display("reset test done");
    for (int n = 0; n < 8; n++) begin
      wr(12'h0334, 8'(1 << n));
      @(negedge clk_sys_i);
      cmp("flip lane", ~(32'hC3A5_0F00 + 32'(n)), lout[n*32 +: 32]);
      cmp("kept", 32'hC3A5_0F00 + 32'((n + 1) % 8), lout[(n + 1) % 8 * 32 +: 32]);
    end
    $display("flip test done");
    run = 1'b1;
    // sample picks not symmetric in the two fields, so a swapped layout shows
    for (int c = 0; c < 4; c++) begin
      s = 4'(c * 5 + 1);
      v = 16'hB000 + 16'(c * 16) + 16'(s);
      wr(12'h032D, v[7:0]);
      wr(12'h032E, v[15:8]);
      wr(12'h032C, {s, 2'(c), 2'b01});
      rdc(12'h032F, 8'h00, "match");
      wr(12'h032C, {~s, 2'(c), 2'b01});
      rdc(12'h032F, 8'h01, "mismatch");
      wr(12'h032C, {~s, 2'(c), 2'b00});
      rdc(12'h032F, 8'h01, "sticky");
      cmp("flag pin", 32'h0000_0001, 32'(flag));
      wr(12'h032C, {~s, 2'(c), 2'b10});
      rdc(12'h032F, 8'h00, "cleared");
    end
    // high byte alone differs, then a clear that meets a live mismatch
    wr(12'h032E, v[15:8] ^ 8'h01);
    wr(12'h032C, {s, 2'd3, 2'b01});
    rdc(12'h032F, 8'h01, "high byte");
    wr(12'h032C, {s, 2'd3, 2'b10});
    rdc(12'h032F, 8'h01, "set wins");
    wr(12'h032C, {s, 2'd3, 2'b10});
    rdc(12'h032F, 8'h00, "late clear");
    run = 1'b0;
    wr(12'h032C, 8'h01);
    rdc(12'h032F, 8'h00, "no valid");
    $display("sample test done");
    send = 1'b1;
    @(negedge clk_sys_i);
    send = 1'b0;
    wr(12'h0400, 8'h00);
    rdc(12'h0400, 8'h5A, "device ident");
    rdc(12'h0401, 8'hC3, "bank ident");
    rst_n = 1'b0;
    @(negedge clk_sys_i);
    rst_n = 1'b1;
    rdc(12'h0400, 8'h00, "ident reset");
    rdc(12'h0401, 8'h00, "bank reset");
    $display("ident test done");
    close_out();
  end
endmodule // tb
`default_nettype wire
